// >>> verilog/charger_consts.vh
// Constants for the charger protection supervisor.
// Assumes a 100 MHz core clock and comparator results as digital inputs.
// Notes on behaviour
// RULE1: Undercurrent latches low side off until next cycle.
// RULE2: Overcurrent limit is programmed current times 145 percent.
// RULE3: Below 3.3 A setting, overcurrent limit fixed 5 A.
// RULE4: Overcurrent stops high side; resumes automatically.
// RULE5: Overvoltage stops switching, with 104/102 percent hysteresis.
// RULE6: Output discharge sink on only while charging.
// RULE7: Low battery forces fixed 220 mA trickle current.
// RULE8: Above 2.7 V, programmed current setting returns.
// RULE9: Input current monitor active only with supply and adapter.
// RULE10: Bus traffic waits for interface supply and reference.
// RULE11: Reference regulator needs supply and adapter bias.
// RULE12: Gate drive needs supply, adapter valid, charge enable.
// RULE13: Thermal shutdown disables the gate drive regulator.
// RULE14: Trip output released low current, pulled low high.
// RULE15: Adapter present output released when adapter valid.
// RULE16: Thermal shutdown holds converter off until cooled.
// RULE17: Watchdog ends charge without commands within 170 s.
// RULE18: After time-out, both commands needed to restart.
// RULE19: Host decides charge start and termination.
// RULE20: Soft start in eight equal 1.6 ms steps.
// RULE21: Charging starts 2 ms after adapter and enable.
// RULE22: Every command write restarts the watchdog.
// RULE23: Comparator results pass two synchroniser flip-flops.
`ifndef CHARGER_CONSTS_VH
`define CHARGER_CONSTS_VH
`define CLK_MHZ 100
`define CHARGE_CURRENT_OFFSET 8'h14
`define CMD_VOLTAGE_OFFSET 8'h15
`define CUR_W 16
`define CUR_RESET 16'h0000
`define TRICKLE_MA 16'h00DC
`define FIXED_OC_MA 16'h1388
`define LOW_CUR_MA 16'h0CE4
`define OC_PCT 145
`define SS_STEP_US 1600
`define SS_STEP_CYC (`SS_STEP_US * `CLK_MHZ)
`define START_DELAY_US 2000
`define START_DELAY_CYC (`START_DELAY_US * `CLK_MHZ)
`define WDOG_S 170
`define WDOG_CYC (64'd170 * 64'd100000000)
`define SS_STEPS 8
`endif

// >>> verilog/soft_start_ramp.v
// Eight-step soft-start ramp of the charge current limit.
// Assumes restart pulses for one cycle when charging becomes enabled.
`timescale 1ns/1ps
`include "charger_consts.vh"
module soft_start_ramp #(
  parameter STEP_CYC = `SS_STEP_CYC
) (
  input wire core_clk,
  input wire rst_n,
  input wire restart,
  input wire [15:0] target,
  output reg [15:0] limit
);
  reg [31:0] cnt_reg;
  reg [3:0] step_reg;
  wire [19:0] prod;
  assign prod = target * step_reg;
  always @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_reg <= 32'h00000000;
      step_reg <= 4'h0;
    end else if (restart) begin
      cnt_reg <= 32'h00000000;
      step_reg <= 4'h1;
    end else if (step_reg != 4'h0 && step_reg < 4'h8) begin
      if (cnt_reg >= STEP_CYC - 1) begin
        cnt_reg <= 32'h00000000;
        step_reg <= step_reg + 4'h1; // [RULE20]
      end else begin
        cnt_reg <= cnt_reg + 32'h00000001;
      end
    end
  end
  always @* begin
    if (step_reg >= 4'h8)
      limit = target;
    else
      limit = prod[18:3]; // [RULE20]
  end
endmodule

// >>> verilog/charger_protection_supervisor.v
// Protection, sequencing and watchdog logic of the battery charger.
// Assumes comparator results and command strobes as core_clk inputs.
`timescale 1ns/1ps
`include "charger_consts.vh"
module charger_protection_supervisor #(
  parameter [63:0] WDOG_CYC = `WDOG_CYC,
  parameter [31:0] START_CYC = `START_DELAY_CYC,
  parameter [31:0] STEP_CYC = `SS_STEP_CYC
) (
  input wire core_clk,
  input wire rst_n,
  input wire cycle_start,
  input wire low_side_req,
  input wire high_side_req,
  input wire cycle_undercurrent_cutoff,
  input wire [15:0] charge_sense_ma,
  input wire fb_above_104,
  input wire fb_below_102,
  input wire fb_below_2v5,
  input wire fb_above_2v7,
  input wire supply_above_4v5,
  input wire supply_above_4v,
  input wire adapter_above_0v6,
  input wire adapter_above_2v4,
  input wire interface_supply_ok,
  input wire reference_ok,
  input wire charge_enable,
  input wire thermal_shutdown_limit,
  input wire thermal_below_135,
  input wire input_current_above_ref,
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  output reg high_side_on,
  output reg low_side_on,
  output reg discharge_sink_en,
  output reg input_current_monitor_out,
  output reg ref_regulator_en,
  output reg gate_drive_regulator,
  output reg bus_ready,
  output reg input_current_trip_out,
  output reg input_current_trip_oe,
  output reg adapter_present_out,
  output reg adapter_present_oe,
  output reg charging,
  output reg [15:0] current_limit,
  output reg watchdog_expired
);
  localparam ST_IDLE = 2'b00;
  localparam ST_DELAY = 2'b01;
  localparam ST_CHARGE = 2'b10;
  localparam ST_HOT = 2'b11;
  // Two-flop synchroniser for comparator inputs.
  localparam NS = 16;
  wire [NS-1:0] raw;
  reg [NS-1:0] sync1_reg;
  reg [NS-1:0] sync2_reg;
  assign raw = {cycle_undercurrent_cutoff, fb_above_104, fb_below_102,
    fb_below_2v5, fb_above_2v7, supply_above_4v5, supply_above_4v,
    adapter_above_0v6, adapter_above_2v4, interface_supply_ok,
    reference_ok, charge_enable, thermal_shutdown_limit,
    thermal_below_135, input_current_above_ref, 1'b0};
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sync1_reg <= {NS{1'b0}};
      sync2_reg <= {NS{1'b0}};
    end else begin
      sync1_reg <= raw; // [RULE23]
      sync2_reg <= sync1_reg; // [RULE23]
    end
  end
  wire s_ucp = sync2_reg[15];
  wire s_ov_hi = sync2_reg[14];
  wire s_ov_lo = sync2_reg[13];
  wire s_fb_lo = sync2_reg[12];
  wire s_fb_hi = sync2_reg[11];
  wire s_sup = sync2_reg[10];
  wire s_sup_min = sync2_reg[9];
  wire s_bias = sync2_reg[8];
  wire s_adapter_present_out = sync2_reg[7];
  wire s_vsmb = sync2_reg[6];
  wire s_vref = sync2_reg[5];
  wire s_ce = sync2_reg[4];
  wire s_hot = sync2_reg[3];
  wire s_cool = sync2_reg[2];
  wire s_itrip = sync2_reg[1];

  reg [15:0] charge_current_setting_reg;
  reg [15:0] voltage_cmd_reg;
  reg v_seen_reg;
  reg i_seen_reg;
  reg [63:0] wdog_reg;
  reg [31:0] delay_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg trickle_reg;
  reg ov_reg;
  reg ucp_latch_reg;
  reg oc_reg;
  wire wr_cur = reg_wr && bus_ready && reg_addr == `CHARGE_CURRENT_OFFSET;
  wire wr_volt = reg_wr && bus_ready && reg_addr == `CMD_VOLTAGE_OFFSET;
  wire enables_ok = s_sup && s_adapter_present_out && s_ce && s_vsmb && s_vref &&
    !watchdog_expired;
  wire [15:0] ramp_limit;
  wire [15:0] target;
  wire [31:0] oc_scaled;
  wire [31:0] oc_div;
  wire [15:0] oc_thresh;
  wire restart = (state_reg == ST_DELAY) && (state_next == ST_CHARGE);

  // Trickle hysteresis selects the fixed current or the setting.
  assign target = trickle_reg ? `TRICKLE_MA :
    charge_current_setting_reg; // [RULE7] [RULE8]
  // Percentage scaling rounds down; the quotient is cut to 16 bits and wraps for large limits.
  assign oc_scaled = current_limit * `OC_PCT;
  assign oc_div = oc_scaled / 32'd100;
  assign oc_thresh = (current_limit < `LOW_CUR_MA) ? `FIXED_OC_MA :
    oc_div[15:0]; // [RULE2] [RULE3]

  soft_start_ramp #(
    .STEP_CYC(STEP_CYC)
  ) ramp (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .restart(restart),
    .target(target),
    .limit(ramp_limit)
  );

  always @(posedge core_clk) begin
    if (!rst_n) begin
      charge_current_setting_reg <= `CUR_RESET;
      voltage_cmd_reg <= `CUR_RESET;
      v_seen_reg <= 1'b0;
      i_seen_reg <= 1'b0;
      wdog_reg <= 64'h0;
      watchdog_expired <= 1'b0;
    end else begin
      if (wr_cur)
        charge_current_setting_reg <= reg_wdata;
      if (wr_volt)
        voltage_cmd_reg <= reg_wdata;
      if (wr_cur || wr_volt) begin
        wdog_reg <= 64'h0; // [RULE22]
      end else if (!watchdog_expired && state_reg == ST_CHARGE) begin
        if (wdog_reg >= WDOG_CYC - 1) begin
          watchdog_expired <= 1'b1; // [RULE17]
          v_seen_reg <= 1'b0;
          i_seen_reg <= 1'b0;
        end else begin
          wdog_reg <= wdog_reg + 64'h1;
        end
      end
      if (watchdog_expired) begin
        if (wr_cur)
          i_seen_reg <= 1'b1;
        if (wr_volt)
          v_seen_reg <= 1'b1;
        if ((i_seen_reg || wr_cur) && (v_seen_reg || wr_volt)) begin
          watchdog_expired <= 1'b0; // [RULE18]
          wdog_reg <= 64'h0;
        end
      end
    end
  end

  // Charging sequence; the host alone ends a charge by current.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (s_hot)
          state_next = ST_HOT;
        else if (enables_ok)
          state_next = ST_DELAY;
      end
      ST_DELAY: begin
        if (s_hot)
          state_next = ST_HOT;
        else if (!enables_ok)
          state_next = ST_IDLE;
        else if (delay_reg >= START_CYC - 1)
          state_next = ST_CHARGE; // [RULE21]
      end
      ST_CHARGE: begin
        if (s_hot)
          state_next = ST_HOT; // [RULE16]
        else if (!enables_ok || !s_sup_min)
          state_next = ST_IDLE; // [RULE19]
      end
      ST_HOT: begin
        if (s_cool && !s_hot)
          state_next = ST_IDLE; // [RULE16]
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      delay_reg <= 32'h0;
      trickle_reg <= 1'b0;
      ov_reg <= 1'b0;
      ucp_latch_reg <= 1'b0;
      oc_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_DELAY)
        delay_reg <= delay_reg + 32'h1;
      else
        delay_reg <= 32'h0;
      if (s_fb_lo)
        trickle_reg <= 1'b1; // [RULE7]
      else if (s_fb_hi)
        trickle_reg <= 1'b0; // [RULE8]
      if (s_ov_hi)
        ov_reg <= 1'b1; // [RULE5]
      else if (s_ov_lo)
        ov_reg <= 1'b0; // [RULE5]
      if (cycle_start)
        ucp_latch_reg <= 1'b0; // [RULE1]
      else if (low_side_on && s_ucp)
        ucp_latch_reg <= 1'b1; // [RULE1]
      oc_reg <= charge_sense_ma > oc_thresh; // [RULE4]
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      high_side_on <= 1'b0;
      low_side_on <= 1'b0;
      discharge_sink_en <= 1'b0;
      input_current_monitor_out <= 1'b0;
      ref_regulator_en <= 1'b0;
      gate_drive_regulator <= 1'b0;
      bus_ready <= 1'b0;
      input_current_trip_out <= 1'b0;
      input_current_trip_oe <= 1'b0;
      adapter_present_out <= 1'b0;
      adapter_present_oe <= 1'b1;
      charging <= 1'b0;
      current_limit <= 16'h0000;
      reg_rdata <= 16'h0000;
    end else begin
      charging <= state_reg == ST_CHARGE;
      current_limit <= (state_reg == ST_CHARGE) ? ramp_limit : 16'h0000;
      high_side_on <= state_reg == ST_CHARGE && high_side_req &&
        !ov_reg && !oc_reg; // [RULE4] [RULE5]
      low_side_on <= state_reg == ST_CHARGE && low_side_req && !ov_reg &&
        !ucp_latch_reg && !(low_side_on && s_ucp); // [RULE1] [RULE5]
      discharge_sink_en <= state_reg == ST_CHARGE; // [RULE6]
      input_current_monitor_out <= s_sup && s_bias; // [RULE9]
      ref_regulator_en <= s_sup && s_bias; // [RULE11]
      gate_drive_regulator <= s_sup && s_adapter_present_out && s_ce &&
        !s_hot && state_reg != ST_HOT; // [RULE12] [RULE13]
      bus_ready <= s_vsmb && s_vref; // [RULE10]
      input_current_trip_oe <= s_itrip; // [RULE14]
      adapter_present_oe <= !s_adapter_present_out; // [RULE15]
      if (reg_addr == `CHARGE_CURRENT_OFFSET)
        reg_rdata <= charge_current_setting_reg;
      else if (reg_addr == `CMD_VOLTAGE_OFFSET)
        reg_rdata <= voltage_cmd_reg;
      else
        reg_rdata <= 16'h0000;
    end
  end
endmodule

// >>> testbench/supervisor_monitor.sv
// Checker for the charger protection supervisor outputs.
// Assumes a lag of about three cycles from comparator input to output.
`timescale 1ns/1ps
module supervisor_monitor (
  input wire core_clk, rst_n, supply_above_4v, adapter_above_2v4,
  input wire thermal_shutdown_limit, input_current_above_ref,
  input wire fb_above_104, reference_ok, cycle_undercurrent_cutoff,
  input wire cycle_start, ref_regulator_en, gate_drive_regulator,
  input wire adapter_present_oe, input_current_trip_oe, discharge_sink_en,
  input wire charging, high_side_on, low_side_on, bus_ready,
  input wire watchdog_expired
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_ref_lockout: assert property (
    (!supply_above_4v)[*6] |-> !ref_regulator_en) else $error("ref on");
  chk_gate_hot: assert property (
    thermal_shutdown_limit[*6] |-> !gate_drive_regulator && !charging)
    else $error("hot drive");
  chk_adapter_flag: assert property (
    adapter_above_2v4[*6] |-> !adapter_present_oe) else $error("adapter");
  chk_trip_pull: assert property (
    input_current_above_ref[*6] |-> input_current_trip_oe)
    else $error("trip");
  chk_sink_charging: assert property (
    discharge_sink_en |-> charging || $past(charging)) else $error("sink");
  chk_overvolt_stop: assert property (
    fb_above_104[*6] |-> !high_side_on && !low_side_on)
    else $error("overvoltage");
  chk_bus_wait: assert property (
    (!reference_ok)[*6] |-> !bus_ready) else $error("bus early");
  chk_ucp_latch: assert property (
    (cycle_undercurrent_cutoff && !cycle_start)[*6] |-> !low_side_on)
    else $error("low side");
  chk_watchdog_stop: assert property (
    watchdog_expired[*3] |-> !charging) else $error("watchdog");
endmodule
bind charger_protection_supervisor supervisor_monitor mon (.*);

// >>> testbench/smbus_host_model.sv
// Host model that issues one-cycle register writes.
// Assumes requests are raised by the bench at the falling edge.
`timescale 1ns/1ps
module smbus_host_model (
  input wire core_clk, rst_n, bus_ready, req,
  input wire [7:0] req_addr,
  input wire [15:0] req_data,
  output reg reg_wr, done,
  output reg [7:0] reg_addr,
  output reg [15:0] reg_wdata
);
  initial {reg_wr, done, reg_addr, reg_wdata} = 0;
  // The host alone decides when a charge is commanded.
  always @(negedge core_clk) begin
    done <= 1'b0;
    if (reg_wr) begin
      reg_wr <= 1'b0;
      reg_wdata <= ~reg_wdata;
      done <= 1'b1;
    end else if (req && !done && rst_n && bus_ready) begin
      reg_wr <= 1'b1;
      reg_addr <= req_addr;
      reg_wdata <= req_data;
    end else if (!req) begin
      reg_addr <= req_addr;
    end
  end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the charger protection supervisor.
// Assumes shortened watchdog, start delay and soft-start step counts.
`timescale 1ns/1ps
module testbench;
  reg core_clk, rst_n, req, cycle_start, low_side_req, high_side_req;
  reg cycle_undercurrent_cutoff, fb_above_104, fb_below_102, fb_below_2v5;
  reg fb_above_2v7, supply_above_4v5, supply_above_4v, adapter_above_0v6;
  reg adapter_above_2v4, interface_supply_ok, reference_ok, charge_enable;
  reg thermal_shutdown_limit, thermal_below_135, input_current_above_ref;
  reg [7:0] req_addr;
  reg [15:0] req_data, charge_sense_ma;
  wire reg_wr, done, high_side_on, low_side_on, discharge_sink_en;
  wire input_current_monitor_out, ref_regulator_en, gate_drive_regulator;
  wire bus_ready, input_current_trip_out, input_current_trip_oe;
  wire adapter_present_out, adapter_present_oe, charging, watchdog_expired;
  wire [7:0] reg_addr;
  wire [15:0] reg_wdata, reg_rdata, current_limit;
  integer n_fail, n_tests, cyc, i;
  charger_protection_supervisor #(.WDOG_CYC(64'd2000),
    .START_CYC(32'd20), .STEP_CYC(32'd10)) DUT (.*);
  smbus_host_model host (.*);
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      print_verdict;
    end
  end
  task print_verdict; begin
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  task ck(input [15:0] got, input [15:0] exp); begin
    n_tests = n_tests + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  task ck1(input g, input e); begin
    ck({15'h0, g}, {15'h0, e});
  end endtask
  task tick(input integer n); begin
    repeat (n) @(negedge core_clk);
  end endtask
  task wr(input [7:0] a, input [15:0] d); begin
    req_addr <= a;
    req_data <= d;
    req <= 1'b1;
    for (i = 0; i < 50 && done !== 1'b1; i = i + 1) @(posedge core_clk);
    tick(1);
    req <= 1'b0;
    tick(1);
  end endtask
  task rd(input [7:0] a, input [15:0] e); begin
    req_addr <= a;
    tick(3);
    ck(reg_rdata, e);
  end endtask
  task wait_chg(input e, input integer n); begin
    for (i = 0; i < n && charging !== e; i = i + 1) tick(1);
  end endtask
  task set_oc(input [15:0] s, input e); begin
    charge_sense_ma <= s;
    tick(8);
    ck1(high_side_on, e);
  end endtask
  initial begin
    {core_clk, rst_n, req, cycle_start, low_side_req, high_side_req,
      cycle_undercurrent_cutoff, fb_above_104, fb_below_102, fb_below_2v5,
      fb_above_2v7, supply_above_4v5, supply_above_4v, adapter_above_0v6,
      adapter_above_2v4, interface_supply_ok, reference_ok, charge_enable,
      thermal_shutdown_limit, thermal_below_135,
      input_current_above_ref} = 0;
    {req_addr, req_data, charge_sense_ma} = 0;
    {n_fail, n_tests, cyc} = 0;
    tick(10);
    rst_n <= 1'b1;
    tick(8);
    ck1(adapter_present_oe, 1'b1);
    ck1(adapter_present_out, 1'b0);
    ck1(input_current_monitor_out, 1'b0);
    {supply_above_4v5, supply_above_4v, adapter_above_0v6,
      adapter_above_2v4, interface_supply_ok, reference_ok, fb_below_102,
      fb_above_2v7, thermal_below_135, high_side_req} <= 10'h3FF;
    tick(8);
    ck1(ref_regulator_en, 1'b1);
    ck1(gate_drive_regulator, 1'b0);
    ck1(adapter_present_oe, 1'b0);
    ck1(input_current_monitor_out, 1'b1);
    ck1(bus_ready, 1'b1);
    wr(8'h14, 16'h07D0);
    wr(8'h15, 16'h1000);
    rd(8'h14, 16'h07D0);
    rd(8'h15, 16'h1000);
    rd(8'h20, 16'h0000);
    charge_enable <= 1'b1;
    wait_chg(1'b1, 200);
    ck1(i >= 20, 1'b1);
    ck1(gate_drive_regulator, 1'b1);
    ck1(discharge_sink_en, 1'b1);
    tick(5);
    ck(current_limit, 16'h00FA);
    tick(80);
    ck(current_limit, 16'h07D0);
    {fb_below_2v5, fb_above_2v7} <= 2'b10;
    tick(8);
    ck(current_limit, 16'h00DC);
    {fb_below_2v5, fb_above_2v7} <= 2'b01;
    tick(8);
    ck(current_limit, 16'h07D0);
    set_oc(16'h1324, 1'b1);
    set_oc(16'h13EC, 1'b0);
    set_oc(16'h0FA0, 1'b1);
    wr(8'h14, 16'h0FA0);
    tick(100);
    set_oc(16'h15E0, 1'b1);
    set_oc(16'h1770, 1'b0);
    set_oc(16'h0000, 1'b1);
    {fb_above_104, fb_below_102} <= 2'b10;
    tick(8);
    ck1(high_side_on, 1'b0);
    fb_above_104 <= 1'b0;
    tick(8);
    ck1(high_side_on, 1'b0);
    fb_below_102 <= 1'b1;
    tick(8);
    ck1(high_side_on, 1'b1);
    {high_side_req, low_side_req, cycle_undercurrent_cutoff} <= 3'b011;
    tick(8);
    cycle_undercurrent_cutoff <= 1'b0;
    tick(8);
    ck1(low_side_on, 1'b0);
    cycle_start <= 1'b1;
    tick(1);
    cycle_start <= 1'b0;
    tick(8);
    ck1(low_side_on, 1'b1);
    input_current_above_ref <= 1'b1;
    tick(8);
    ck1(input_current_trip_oe, 1'b1);
    ck1(input_current_trip_out, 1'b0);
    {thermal_shutdown_limit, thermal_below_135} <= 2'b10;
    tick(8);
    ck1(gate_drive_regulator, 1'b0);
    thermal_shutdown_limit <= 1'b0;
    tick(8);
    ck1(charging, 1'b0);
    thermal_below_135 <= 1'b1;
    wait_chg(1'b1, 200);
    ck1(gate_drive_regulator, 1'b1);
    tick(1500);
    wr(8'h15, 16'h1000);
    tick(1000);
    ck1(watchdog_expired, 1'b0);
    wait_chg(1'b0, 2600);
    ck1(watchdog_expired, 1'b1);
    wr(8'h14, 16'h07D0);
    tick(100);
    ck1(charging, 1'b0);
    wr(8'h15, 16'h1000);
    wait_chg(1'b1, 200);
    ck1(charging, 1'b1);
    print_verdict;
  end
endmodule
